// file: hw/pcs_core.sv
// Program counter with upper latch and circular return stack
`timescale 1ns/1ns
// Function
// - Thirteen-bit counter; low byte readable and writable through the core.
// - Upper five counter bits are hidden; changed only via the upper latch.
// - Any reset clears the upper counter bits.
// - Low byte write loads byte and copies all five latch bits upward.
// - Call or jump takes top two bits from latch bits four and three.
// - Call and jump supply eleven address bits within one 2K page.
// - Adding to the low byte never carries into the upper bits.
// - Return stack has eight entries of thirteen bits.
// - Stack and its pointer are invisible to software.
// - Call pushes counter plus one; interrupt vectoring pushes the current counter.
// - Return, return with literal, return from interrupt pop the stack.
// - Pop restores the whole thirteen-bit counter.
// - Push and pop leave the upper latch unchanged.
// - Stack is circular; ninth push overwrites the first entry.
// - No overflow or underflow indication exists.
// - Pushes and pops only come from call, return and vectoring.
// - Low byte and latch reachable from every bank; bank is ignored.
module pcs_core
    import pcs_pkg::*;
#(
    parameter int unsigned DEPTH = STACK_DEPTH
) (
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset_n,
    // Decoder request
    input  wire pcs_req_t          i_req,
    // Upper latch write from the core
    input  wire logic              i_latch_we,
    input  wire logic [4:0]        i_latch_data,
    // Counter outputs
    output logic [12:0]            o_pc,
    output logic [7:0]             o_program_counter_low,
    output logic [4:0]             o_program_counter_upper_latch
);
    localparam int unsigned PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("pcs_core: DEPTH must be a power of two, at least 2");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [12:0]      pc;
    logic [4:0]       upper_latch;
    logic [12:0]      stack_mem [DEPTH];
    logic [PW-1:0]    stack_ptr;
    logic [12:0]      next_pc;
    logic [PW-1:0]    pop_ptr;
    logic             push_en;
    logic             pop_en;
    logic [12:0]      pop_value;

    // ------------------------------------------------------------
    // Stack decode
    // ------------------------------------------------------------
    // Pop reads the entry below the pointer; an empty stack wraps silently
    assign pop_ptr   = stack_ptr - PW'(1);
    assign pop_value = stack_mem[pop_ptr];
    // Only calls, vectoring and returns move the stack; nothing else can
    assign push_en   = (i_req.op == PCS_OP_CALL) || (i_req.op == PCS_OP_VECTOR);
    assign pop_en    = (i_req.op == PCS_OP_RETURN);

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Fetch address is full width; software only ever sees the low byte
    assign o_pc                          = pc;
    assign o_program_counter_low         = pc[7:0];
    assign o_program_counter_upper_latch = upper_latch;

    // ------------------------------------------------------------
    // Next counter value
    // ------------------------------------------------------------
    // Next counter value per operation
    always_comb begin
        next_pc = pc;
        unique case (i_req.op)
            PCS_OP_HOLD:      next_pc = pc;
            PCS_OP_NEXT:      next_pc = pc + 13'h0001;
            PCS_OP_JUMP,
            PCS_OP_CALL:      next_pc = {upper_latch[4:3], i_req.target};
            PCS_OP_RETURN:    next_pc = pop_value;
            PCS_OP_VECTOR:    next_pc = i_req.vector;
            PCS_OP_LOW_WRITE: next_pc = {upper_latch, i_req.low_data};
            default:          next_pc = pc;
        endcase
    end

    // ------------------------------------------------------------
    // Counter and upper latch
    // ------------------------------------------------------------
    // Program counter; reset clears all bits including the upper ones
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            pc <= PC_RESET;
        end else begin
            pc <= next_pc;
        end
    end

    // Upper latch only changes on its own write, never by stack activity
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            upper_latch <= LATCH_RESET;
        end else if (i_latch_we) begin
            upper_latch <= i_latch_data;
        end
    end

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    // Stack pointer wraps freely; no status flags are kept
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            stack_ptr <= '0;
        end else if (push_en) begin
            stack_ptr <= stack_ptr + PW'(1);
        end else if (pop_en) begin
            stack_ptr <= pop_ptr;
        end
    end

    // Stack storage, hidden from any address space
    genvar gi;
    for (gi = 0; gi < DEPTH; gi++) begin : g_stack
        always_ff @(posedge i_clk_sys) begin
            if (!i_reset_n) begin
                stack_mem[gi] <= PC_RESET;
            end else if (push_en && stack_ptr == PW'(gi)) begin
                // Call pushes the return address, vectoring the current one
                stack_mem[gi] <= (i_req.op == PCS_OP_CALL) ? pc + 13'h0001 : pc;
            end
        end

        // An entry only changes when the pointer selects it for a push
        property p_entry_kept;
            @(posedge i_clk_sys) disable iff (!i_reset_n)
            !(push_en && stack_ptr == PW'(gi)) |=> $stable(stack_mem[gi]);
        endproperty
        a_entry_kept: assert property (p_entry_kept) else $error("stack entry changed without push");

        // Every entry starts clean after a reset
        property p_entry_reset;
            @(posedge i_clk_sys) !i_reset_n |=> stack_mem[gi] == PC_RESET;
        endproperty
        a_entry_reset: assert property (p_entry_reset) else $error("stack entry not cleared");
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reset_clear;
        @(posedge i_clk_sys) !i_reset_n |=> (pc == 13'h0000 && stack_ptr == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear pc");

    property p_low_write;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_LOW_WRITE) |=> pc == {$past(upper_latch), $past(i_req.low_data)};
    endproperty
    a_low_write: assert property (p_low_write) else $error("low write load wrong");

    property p_page_jump;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_JUMP) |=> pc == {$past(upper_latch[4:3]), $past(i_req.target)};
    endproperty
    a_page_jump: assert property (p_page_jump) else $error("jump target wrong");

    property p_advance;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_NEXT) |=> pc == $past(pc) + 13'h0001;
    endproperty
    a_advance: assert property (p_advance) else $error("pc did not advance");

    property p_call_return;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_CALL) ##1 (i_req.op == PCS_OP_RETURN) |=> pc == $past(pc, 2) + 13'h0001;
    endproperty
    a_call_return: assert property (p_call_return) else $error("return address wrong");

    property p_latch_kept;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (!i_latch_we && i_req.op inside {PCS_OP_CALL, PCS_OP_RETURN}) |=> $stable(upper_latch);
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("latch changed by stack");

    property p_push_ptr;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_VECTOR) |=> stack_ptr == $past(stack_ptr) + PW'(1);
    endproperty
    a_push_ptr: assert property (p_push_ptr) else $error("push pointer wrong");

    property p_pop_ptr;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_RETURN) |=> stack_ptr == $past(stack_ptr) - PW'(1);
    endproperty
    a_pop_ptr: assert property (p_pop_ptr) else $error("pop pointer wrong");

    property p_vector_saves;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_VECTOR) |=> stack_mem[$past(stack_ptr)] == $past(pc);
    endproperty
    a_vector_saves: assert property (p_vector_saves) else $error("vector push wrong");

    // Calls page through the latch exactly as jumps do
    property p_call_target;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_CALL) |=> pc == {$past(upper_latch[4:3]), $past(i_req.target)};
    endproperty
    a_call_target: assert property (p_call_target) else $error("call target wrong");

    property p_call_saves;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_CALL) |=> stack_mem[$past(stack_ptr)] == $past(pc) + 13'h0001;
    endproperty
    a_call_saves: assert property (p_call_saves) else $error("call push wrong");

    // Wrap is silent: the pointer just moves on, no flag is raised
    property p_call_ptr;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_CALL) |=> stack_ptr == $past(stack_ptr) + PW'(1);
    endproperty
    a_call_ptr: assert property (p_call_ptr) else $error("call pointer wrong");

    property p_return_load;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_RETURN) |=> pc == $past(pop_value);
    endproperty
    a_return_load: assert property (p_return_load) else $error("return load wrong");

    property p_vector_load;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_VECTOR) |=> pc == $past(i_req.vector);
    endproperty
    a_vector_load: assert property (p_vector_load) else $error("vector load wrong");

    // Vectoring then return from interrupt resumes the interrupted address
    property p_vector_return;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_VECTOR) ##1 (i_req.op == PCS_OP_RETURN) |=> pc == $past(pc, 2);
    endproperty
    a_vector_return: assert property (p_vector_return) else $error("interrupt return wrong");

    // Nested calls unwind in reverse order
    property p_nested_calls;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_CALL) ##1 (i_req.op == PCS_OP_CALL) ##1 (i_req.op == PCS_OP_RETURN)
            ##1 (i_req.op == PCS_OP_RETURN) |=> pc == $past(pc, 4) + 13'h0001;
    endproperty
    a_nested_calls: assert property (p_nested_calls) else $error("nested return wrong");

    property p_hold;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_HOLD) |=> $stable(pc);
    endproperty
    a_hold: assert property (p_hold) else $error("pc moved on hold");

    property p_stack_idle;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !(push_en || pop_en) |=> $stable(stack_ptr);
    endproperty
    a_stack_idle: assert property (p_stack_idle) else $error("pointer moved without stack op");

    // Latch is the only way into the hidden upper bits
    property p_latch_write;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_latch_we |=> upper_latch == $past(i_latch_data);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");

    property p_latch_idle;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_latch_we |=> $stable(upper_latch);
    endproperty
    a_latch_idle: assert property (p_latch_idle) else $error("latch changed without write");

    property p_latch_reset;
        @(posedge i_clk_sys) !i_reset_n |=> upper_latch == LATCH_RESET;
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("reset did not clear latch");

    // A computed low byte never disturbs the page bits
    property p_low_upper;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_req.op == PCS_OP_LOW_WRITE) |=> pc[12:8] == $past(upper_latch);
    endproperty
    a_low_upper: assert property (p_low_upper) else $error("low write carried upward");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    // Main scenarios: call, wrap of the pointer, low write, return, vectoring
    c_call:   cover property (@(posedge i_clk_sys) i_req.op == PCS_OP_CALL);
    c_wrap:   cover property (@(posedge i_clk_sys) i_req.op == PCS_OP_CALL && stack_ptr == PW'(DEPTH - 1));
    c_lowwr:  cover property (@(posedge i_clk_sys) i_req.op == PCS_OP_LOW_WRITE);
    c_return: cover property (@(posedge i_clk_sys) i_req.op == PCS_OP_RETURN);
    c_vector: cover property (@(posedge i_clk_sys) i_req.op == PCS_OP_VECTOR);
endmodule : pcs_core

// file: inc/pcs_pkg.sv
// Package for the program counter and return stack block
package pcs_pkg;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned PC_WIDTH     = 13;
    localparam int unsigned LOW_WIDTH    = 8;
    localparam int unsigned HIGH_WIDTH   = 5;
    localparam int unsigned PAGE_BITS    = 11;
    localparam int unsigned PAGE_SEL_LSB = 3;
    localparam int unsigned STACK_DEPTH  = 8;
    localparam logic [12:0] PC_RESET     = 13'h0000;
    localparam logic [4:0]  LATCH_RESET  = 5'h00;

    // Program counter operation requested by the decoder
    typedef enum logic [2:0] {
        PCS_OP_HOLD,
        PCS_OP_NEXT,
        PCS_OP_JUMP,
        PCS_OP_CALL,
        PCS_OP_RETURN,
        PCS_OP_VECTOR,
        PCS_OP_LOW_WRITE
    } pcs_op_t;

    // Request from the core decoder
    typedef struct packed {
        pcs_op_t     op;
        logic [10:0] target;
        logic [7:0]  low_data;
        logic [12:0] vector;
    } pcs_req_t;
endpackage : pcs_pkg

// file: sim/pcs_decoder_model.sv
// Decoder model that presents one core request per cycle
`timescale 1ns/1ns
module pcs_decoder_model
    import pcs_pkg::*;
#(
    parameter logic [12:0] VEC = 13'h0004
) (
    // Clock
    input  wire logic       i_clk_sys,
    // Requests toward the counter
    output pcs_req_t        o_req,
    output logic            o_latch_we,
    output logic [4:0]      o_latch_data
);
    // ------------------------------------------------------------
    // Request driver
    // ------------------------------------------------------------
    // Idle request from time zero so reset never sees unknowns
    initial begin
        o_req = '{PCS_OP_HOLD, 11'h000, 8'h00, VEC};
        o_latch_we = 1'b0;
        o_latch_data = 5'h00;
    end
    // Changes only at the falling edge, held through one rising edge
    task automatic issue(input pcs_op_t op, input logic [10:0] tgt, input logic [7:0] low,
                         input logic we, input logic [4:0] lv);
        @(negedge i_clk_sys);
        o_req = '{op, tgt, low, VEC};
        o_latch_we = we;
        o_latch_data = lv;
    endtask : issue
endmodule : pcs_decoder_model

// file: sim/program_counter_and_return_stack_tb.sv
// Testbench for the program counter and return stack
`timescale 1ns/1ns
module program_counter_and_return_stack_tb
    import pcs_pkg::*;
;
    localparam logic [12:0] VEC = 13'h0004;
    logic            i_clk_sys = 1'b0;
    logic            i_reset_n = 1'b0;
    pcs_req_t        req;
    logic            we;
    logic [4:0]      ld;
    logic [12:0]     pc;
    logic [7:0]      program_counter_low;
    logic [4:0]      lat;
    logic [12:0]     stk [8];
    logic [12:0]     epc;
    logic [4:0]      elat;
    logic [2:0]      sp;
    int              num_errors = 0;
    int              checks = 0;
    // 100 MHz core clock
    always #5 i_clk_sys = ~i_clk_sys;
    pcs_decoder_model #(.VEC(VEC)) u_dec (.i_clk_sys(i_clk_sys), .o_req(req), .o_latch_we(we), .o_latch_data(ld));
    pcs_core u_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_req(req), .i_latch_we(we),
                    .i_latch_data(ld), .o_pc(pc), .o_program_counter_low(program_counter_low), .o_program_counter_upper_latch(lat));
    // ------------------------------------------------------------
    // Shared checking and stepping
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Reference model: 3-bit pointer wraps just like the circular stack
    task automatic step(input pcs_op_t op, input logic [10:0] t, input logic [7:0] low,
                        input logic w = 1'b0, input logic [4:0] lv = 5'h00);
        u_dec.issue(op, t, low, w, lv);
        // Counter sees the latch as it stood before this edge
        case (op)
            PCS_OP_NEXT: epc = epc + 13'h0001;
            PCS_OP_JUMP: epc = {elat[4:3], t};
            PCS_OP_CALL: begin
                stk[sp] = epc + 13'h0001;
                sp++;
                epc = {elat[4:3], t};
            end
            PCS_OP_VECTOR: begin
                stk[sp] = epc;
                sp++;
                epc = VEC;
            end
            PCS_OP_RETURN: begin
                sp--;
                epc = stk[sp];
            end
            PCS_OP_LOW_WRITE: epc = {elat, low};
            default: ;
        endcase
        if (w) elat = lv;
        @(posedge i_clk_sys);
        #1;
        check("pc", pc, epc);
        check("low", {5'h00, program_counter_low}, {5'h00, epc[7:0]});
        check("latch", {8'h00, lat}, {8'h00, elat});
    endtask : step
    task automatic do_reset();
        // Idle request goes out with reset so no stale operation runs at release
        u_dec.issue(PCS_OP_HOLD, 11'h000, 8'h00, 1'b0, 5'h00);
        i_reset_n = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1;
        epc = 13'h0000;
        elat = 5'h00;
        sp = 3'h0;
        foreach (stk[i]) stk[i] = 13'h0000;
        check("reset pc", pc, epc);
        check("reset latch", {8'h00, lat}, 13'h0000);
        @(negedge i_clk_sys);
        i_reset_n = 1'b1;
    endtask : do_reset
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_linear();
        repeat (3) step(PCS_OP_NEXT, 11'h000, 8'h00);
        step(PCS_OP_HOLD, 11'h000, 8'h00, 1'b1, 5'h1B);
        step(PCS_OP_LOW_WRITE, 11'h000, 8'hFF);
        step(PCS_OP_LOW_WRITE, 11'h000, 8'h01);
        $display("test linear done");
    endtask : t_linear
    task automatic t_page();
        step(PCS_OP_HOLD, 11'h000, 8'h00, 1'b1, 5'h10);
        step(PCS_OP_JUMP, 11'h7FF, 8'h00);
        step(PCS_OP_HOLD, 11'h000, 8'h00, 1'b1, 5'h0F);
        step(PCS_OP_JUMP, 11'h001, 8'h00);
        // Latch write in the jump's cycle: jump uses the old page bits
        step(PCS_OP_JUMP, 11'h100, 8'h00, 1'b1, 5'h07);
        $display("test page done");
    endtask : t_page
    // Nine calls overrun the stack by one, then nine returns
    task automatic t_stack();
        step(PCS_OP_HOLD, 11'h000, 8'h00, 1'b1, 5'h08);
        for (int i = 0; i < 9; i++) step(PCS_OP_CALL, 11'(i * 16 + 3), 8'h00);
        repeat (9) step(PCS_OP_RETURN, 11'h000, 8'h00);
        step(PCS_OP_NEXT, 11'h000, 8'h00);
        step(PCS_OP_VECTOR, 11'h000, 8'h00);
        step(PCS_OP_RETURN, 11'h000, 8'h00);
        $display("test stack done");
    endtask : t_stack
    task automatic t_reset_mid();
        step(PCS_OP_HOLD, 11'h000, 8'h00, 1'b1, 5'h18);
        step(PCS_OP_CALL, 11'h555, 8'h00);
        do_reset();
        step(PCS_OP_CALL, 11'h123, 8'h00);
        step(PCS_OP_RETURN, 11'h000, 8'h00);
        // Underflow wraps silently to the last, cleared entry
        step(PCS_OP_RETURN, 11'h000, 8'h00);
        $display("test reset done");
    endtask : t_reset_mid
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    initial begin
        do_reset();
        t_linear();
        t_page();
        t_stack();
        t_reset_mid();
        end_sim();
    end
endmodule : program_counter_and_return_stack_tb
